// ==== hdl/dtc_top.sv ====
// Dual 16-bit timer/counter with external interrupt flags, APB register slave.
// Assumes APB and the core's vector acknowledges run on CORE_CLK; pins are async.
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE1 - overflow one flag set, cleared on vector
// RULE2 - overflow zero flag set, vector or software clear
// RULE3 - run bit one stops or runs timer one, except in split mode of timer zero, where timer one ignores run bit one
// RULE4 - run bit zero stops or runs timer zero
// RULE5 - pin flag set; edge mode clears on service
// RULE6 - type bit: zero low level, one falling edge
// RULE7 - gate one: count only while pin high
// RULE8 - gate zero: count only while pin high
// RULE9 - timer one source: tick or pin falls
// RULE10 - timer zero source: tick or pin falls
// RULE11 - modes: 13-bit, 16-bit, reload, split/halt
// RULE12 - reload low byte from high on overflow
// RULE13 - split mode: high byte uses one's controls
// RULE14 - four count bytes readable and writable
// RULE15 - count bytes reset to zero
// RULE16 - 13-bit mode uses low five prescaler bits
// RULE17 - timer mode counts once per peripheral cycle
// RULE18 - counter mode counts sampled high-then-low
// RULE19 - software stops timer before mode change
// RULE20 - interrupt pins synchronised before use
// RULE21 - writes land next cycle; hardware set wins
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        EXT_IRQ_PIN_ZERO_N,
    input  wire logic        EXT_IRQ_PIN_ONE_N,
    input  wire logic        EVENT_PIN_ZERO,
    input  wire logic        EVENT_PIN_ONE,
    input  wire logic        IRQ_ACK_OVF_ZERO,
    input  wire logic        IRQ_ACK_OVF_ONE,
    input  wire logic        IRQ_ACK_EXT_ZERO,
    input  wire logic        IRQ_ACK_EXT_ONE,
    output var  logic        OVERFLOW_FLAG_ZERO,
    output var  logic        OVERFLOW_FLAG_ONE,
    output var  logic        EXT_IRQ_FLAG_ZERO,
    output var  logic        EXT_IRQ_FLAG_ONE
);

    // Address match against a register index
    function automatic logic dtc_hit(input logic [11:0] addr, input logic [7:0] idx);
        return addr == {2'h0, idx, 2'h0};
    endfunction

    // One count step: returns {overflow, high, low}
    function automatic logic [16:0] dtc_count(input logic [1:0] md, input logic [7:0] th,
                                              input logic [7:0] tl, input logic inc);
        logic [16:0] r;
        logic [5:0]  p;
        logic [8:0]  h;
        logic [8:0]  l;
        r = {1'b0, th, tl};
        p = 6'h00;
        h = 9'h000;
        l = 9'h000;
        if (inc) begin
            case (md)
                MODE_13BIT: begin
                    p = {1'b0, tl[4:0]} + 6'h01;                        // [RULE16]
                    h = {1'b0, th} + {8'h00, p[5]};
                    r = {h[8], h[7:0], tl[7:5], p[4:0]};
                end
                MODE_16BIT: begin
                    r = {1'b0, th, tl} + 17'h00001;
                end
                MODE_RELOAD: begin
                    l = {1'b0, tl} + 9'h001;
                    r = {l[8], th, (l[8] ? th : l[7:0])};               // [RULE12]
                end
                default: begin
                    r = {1'b0, th, tl};                                 // [RULE11]
                end
            endcase
        end
        return r;
    endfunction

    dtc_state_t st;
    dtc_state_t nx;

    logic        tick;
    logic [1:0]  evt_fall;
    logic [1:0]  ext_fall;
    logic [1:0]  pin_high;
    logic [1:0]  m0;
    logic [1:0]  m1;
    logic        en0;
    logic        en1;
    logic        inc0;
    logic        inc1;
    logic        run1_ok;
    logic        ovf0;
    logic        ovf1;
    logic        ovf_h;
    logic [16:0] res0;
    logic [16:0] res1;
    logic [8:0]  sum_l;
    logic [8:0]  sum_h;
    logic        access;
    logic        mapped;
    logic        do_wr;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic        wr_ctl;
    logic        set_tf0;
    logic        set_tf1;

    always_comb begin
        nx = st;
        // Two-stage synchronisers, third stage keeps previous level
        nx.sync1 = {EVENT_PIN_ONE, EVENT_PIN_ZERO, EXT_IRQ_PIN_ONE_N, EXT_IRQ_PIN_ZERO_N};
        nx.sync2 = st.sync1;                                            // [RULE20]
        nx.sync3 = st.sync2;
        pin_high = st.sync2[1:0];
        ext_fall = st.sync3[1:0] & ~st.sync2[1:0];                      // [RULE20]

        // Peripheral cycle divider
        tick = (st.div == DIV_LAST);                                    // [RULE17]
        nx.div = tick ? DIV_RESET : st.div + 3'h1;
        if (tick) begin
            nx.evt_prev = st.sync2[3:2];                                // [RULE18]
        end
        evt_fall = {2{tick}} & st.evt_prev & ~st.sync2[3:2];           // [RULE18]

        m0 = st.mode[MOD_MODE_HIGH_BIT_ZERO:MOD_MODE_LOW_BIT_ZERO];
        m1 = st.mode[MOD_MODE_HIGH_BIT_ONE:MOD_MODE_LOW_BIT_ONE];

        // Count enables and sources
        en0 = st.ctl[CTL_RUN_BIT_ZERO]                                  // [RULE4]
            & (~st.mode[MOD_PIN_GATING_ZERO] | pin_high[0]);            // [RULE8]
        run1_ok = (m0 == MODE_SPLIT) ? 1'b1 : st.ctl[CTL_RUN_BIT_ONE];  // [RULE3]
        en1 = run1_ok & (~st.mode[MOD_PIN_GATING_ONE] | pin_high[1]);   // [RULE7]
        inc0 = en0 & (st.mode[MOD_SOURCE_SELECT_ZERO] ? evt_fall[0] : tick); // [RULE10]
        inc1 = en1 & (st.mode[MOD_SOURCE_SELECT_ONE] ? evt_fall[1] : tick);  // [RULE9]

        // Timer zero
        sum_l = 9'h000;
        sum_h = 9'h000;
        res0 = 17'h00000;
        ovf_h = 1'b0;
        if (m0 == MODE_SPLIT) begin
            sum_l = {1'b0, st.tl0} + {8'h00, inc0};                     // [RULE13]
            sum_h = {1'b0, st.th0} + {8'h00, tick & st.ctl[CTL_RUN_BIT_ONE]};
            ovf0 = sum_l[8];
            ovf_h = sum_h[8];
            nx.tl0 = sum_l[7:0];
            nx.th0 = sum_h[7:0];
        end else begin
            res0 = dtc_count(m0, st.th0, st.tl0, inc0);                 // [RULE11]
            ovf0 = res0[16];
            nx.th0 = res0[15:8];
            nx.tl0 = res0[7:0];
        end

        // Timer one; its flag goes to the split high byte in mode 3 of timer zero
        res1 = dtc_count(m1, st.th1, st.tl1, inc1);
        ovf1 = res1[16];
        nx.th1 = res1[15:8];
        nx.tl1 = res1[7:0];
        set_tf0 = ovf0;
        set_tf1 = (m0 == MODE_SPLIT) ? ovf_h : ovf1;                    // [RULE13]

        // APB slave, one wait state
        access = PSEL & PENABLE;
        mapped = dtc_hit(PADDR, IDX_TIMER_CONTROL)
               | dtc_hit(PADDR, IDX_TIMER_MODE_CONTROL)
               | dtc_hit(PADDR, IDX_TIMER_ZERO_LOW_BYTE)
               | dtc_hit(PADDR, IDX_TIMER_ONE_LOW_BYTE)
               | dtc_hit(PADDR, IDX_TIMER_ZERO_HIGH_BYTE)
               | dtc_hit(PADDR, IDX_TIMER_ONE_HIGH_BYTE);
        do_wr = access & st.ready & PWRITE & mapped;
        wd = PWDATA[7:0];
        rd = 8'h00;
        if (dtc_hit(PADDR, IDX_TIMER_CONTROL)) begin
            rd = st.ctl;
        end else if (dtc_hit(PADDR, IDX_TIMER_MODE_CONTROL)) begin
            rd = st.mode;
        end else if (dtc_hit(PADDR, IDX_TIMER_ZERO_LOW_BYTE)) begin
            rd = st.tl0;                                                // [RULE14]
        end else if (dtc_hit(PADDR, IDX_TIMER_ONE_LOW_BYTE)) begin
            rd = st.tl1;
        end else if (dtc_hit(PADDR, IDX_TIMER_ZERO_HIGH_BYTE)) begin
            rd = st.th0;
        end else if (dtc_hit(PADDR, IDX_TIMER_ONE_HIGH_BYTE)) begin
            rd = st.th1;
        end
        if (access & ~st.ready) begin
            nx.ready = 1'b1;
            nx.slverr = ~mapped;
            nx.rdata = {24'h000000, rd};
        end else begin
            nx.ready = 1'b0;
            nx.slverr = 1'b0;
            nx.rdata = 32'h00000000;
        end

        // Software preload overrides the count step
        if (do_wr && dtc_hit(PADDR, IDX_TIMER_ZERO_LOW_BYTE)) begin
            nx.tl0 = wd;                                                // [RULE14]
        end
        if (do_wr && dtc_hit(PADDR, IDX_TIMER_ONE_LOW_BYTE)) begin
            nx.tl1 = wd;
        end
        if (do_wr && dtc_hit(PADDR, IDX_TIMER_ZERO_HIGH_BYTE)) begin
            nx.th0 = wd;
        end
        if (do_wr && dtc_hit(PADDR, IDX_TIMER_ONE_HIGH_BYTE)) begin
            nx.th1 = wd;
        end
        if (do_wr && dtc_hit(PADDR, IDX_TIMER_MODE_CONTROL)) begin
            nx.mode = wd;                                               // [RULE21]
        end

        // Control register: plain bits follow the write, flags let a set win
        wr_ctl = do_wr & dtc_hit(PADDR, IDX_TIMER_CONTROL);
        if (wr_ctl) begin
            nx.ctl[CTL_RUN_BIT_ONE] = wd[CTL_RUN_BIT_ONE];              // [RULE21]
            nx.ctl[CTL_RUN_BIT_ZERO] = wd[CTL_RUN_BIT_ZERO];
            nx.ctl[CTL_EXT_IRQ_TYPE_ONE] = wd[CTL_EXT_IRQ_TYPE_ONE];
            nx.ctl[CTL_EXT_IRQ_TYPE_ZERO] = wd[CTL_EXT_IRQ_TYPE_ZERO];
        end
        nx.ctl[CTL_OVERFLOW_FLAG_ONE] = set_tf1                          // [RULE1]
            | (wr_ctl ? wd[CTL_OVERFLOW_FLAG_ONE]
                      : st.ctl[CTL_OVERFLOW_FLAG_ONE] & ~IRQ_ACK_OVF_ONE);
        nx.ctl[CTL_OVERFLOW_FLAG_ZERO] = set_tf0                         // [RULE2]
            | (wr_ctl ? wd[CTL_OVERFLOW_FLAG_ZERO]
                      : st.ctl[CTL_OVERFLOW_FLAG_ZERO] & ~IRQ_ACK_OVF_ZERO);
        if (st.ctl[CTL_EXT_IRQ_TYPE_ZERO]) begin
            nx.ctl[CTL_EXT_IRQ_FLAG_ZERO] = ext_fall[0]                  // [RULE5] [RULE6]
                | (wr_ctl ? wd[CTL_EXT_IRQ_FLAG_ZERO]
                          : st.ctl[CTL_EXT_IRQ_FLAG_ZERO] & ~IRQ_ACK_EXT_ZERO);
        end else begin
            nx.ctl[CTL_EXT_IRQ_FLAG_ZERO] = ~pin_high[0];               // [RULE6]
        end
        if (st.ctl[CTL_EXT_IRQ_TYPE_ONE]) begin
            nx.ctl[CTL_EXT_IRQ_FLAG_ONE] = ext_fall[1]                   // [RULE5] [RULE6]
                | (wr_ctl ? wd[CTL_EXT_IRQ_FLAG_ONE]
                          : st.ctl[CTL_EXT_IRQ_FLAG_ONE] & ~IRQ_ACK_EXT_ONE);
        end else begin
            nx.ctl[CTL_EXT_IRQ_FLAG_ONE] = ~pin_high[1];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st.ctl      <= RST_TIMER_CONTROL;
            st.mode     <= RST_TIMER_MODE;
            st.tl0      <= RST_COUNT_BYTE;                              // [RULE15]
            st.th0      <= RST_COUNT_BYTE;
            st.tl1      <= RST_COUNT_BYTE;
            st.th1      <= RST_COUNT_BYTE;
            st.div      <= DIV_RESET;
            st.sync1    <= SYNC_RESET;
            st.sync2    <= SYNC_RESET;
            st.sync3    <= SYNC_RESET;
            st.evt_prev <= 2'h3;
            st.ready    <= 1'b0;
            st.slverr   <= 1'b0;
            st.rdata    <= 32'h00000000;
        end else begin
            st <= nx;
        end
    end

    assign PRDATA             = st.rdata;
    assign PREADY             = st.ready;
    assign PSLVERR            = st.slverr;
    assign OVERFLOW_FLAG_ZERO = st.ctl[CTL_OVERFLOW_FLAG_ZERO];
    assign OVERFLOW_FLAG_ONE  = st.ctl[CTL_OVERFLOW_FLAG_ONE];
    assign EXT_IRQ_FLAG_ZERO  = st.ctl[CTL_EXT_IRQ_FLAG_ZERO];
    assign EXT_IRQ_FLAG_ONE   = st.ctl[CTL_EXT_IRQ_FLAG_ONE];

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_tick_gap;
        !tick [*5] ##1 tick;
    endsequence

    a_tick_period: assert property (tick |=> s_tick_gap) // [RULE17]
        else $error("peripheral tick period wrong");

    a_ovf1_vector_clear: assert property ( // [RULE1]
        (OVERFLOW_FLAG_ONE && IRQ_ACK_OVF_ONE && !set_tf1 && !wr_ctl) |=> !OVERFLOW_FLAG_ONE)
        else $error("overflow one flag not cleared by vector");

    a_ovf0_set_wins: assert property ( // [RULE2]
        set_tf0 |=> OVERFLOW_FLAG_ZERO)
        else $error("overflow zero flag lost");

    a_run1_stop: assert property ( // [RULE3]
        (!st.ctl[CTL_RUN_BIT_ONE] && m0 != MODE_SPLIT && !do_wr)
        |=> ($stable(st.tl1) && $stable(st.th1)))
        else $error("timer one counted while stopped");

    a_run0_stop: assert property ( // [RULE4]
        (!st.ctl[CTL_RUN_BIT_ZERO] && m0 != MODE_SPLIT && !do_wr)
        |=> ($stable(st.tl0) && $stable(st.th0)))
        else $error("timer zero counted while stopped");

    a_ext_edge_set: assert property ( // [RULE5]
        (st.ctl[CTL_EXT_IRQ_TYPE_ZERO] && ext_fall[0]) |=> EXT_IRQ_FLAG_ZERO)
        else $error("edge interrupt zero missed");

    a_ext_level_follow: assert property ( // [RULE6]
        !st.ctl[CTL_EXT_IRQ_TYPE_ONE] |=> (EXT_IRQ_FLAG_ONE == !$past(pin_high[1])))
        else $error("level interrupt one not following pin");

    a_pin_gating_zero_block: assert property ( // [RULE8]
        (st.mode[MOD_PIN_GATING_ZERO] && !pin_high[0] && m0 != MODE_SPLIT && !do_wr)
        |=> $stable(st.tl0))
        else $error("gated timer zero counted with pin low");

    a_reload_low: assert property ( // [RULE12]
        (m0 == MODE_RELOAD && ovf0 && !do_wr)
        |=> (st.tl0 == $past(st.th0) && $stable(st.th0) && OVERFLOW_FLAG_ZERO))
        else $error("auto-reload wrong");

    a_ovf1_set_wins: assert property ( // [RULE21]
        set_tf1 |=> OVERFLOW_FLAG_ONE)
        else $error("overflow one flag lost to a clear");

    a_pin_gating_one_block: assert property ( // [RULE7]
        (st.mode[MOD_PIN_GATING_ONE] && !pin_high[1] && !do_wr) |=> $stable(st.tl1))
        else $error("gated timer one counted with pin low");

    a_src0_events: assert property ( // [RULE10]
        (st.mode[MOD_SOURCE_SELECT_ZERO] && !evt_fall[0] && !do_wr) |=> $stable(st.tl0))
        else $error("counter zero stepped without a pin fall");

    a_src1_events: assert property ( // [RULE9]
        (st.mode[MOD_SOURCE_SELECT_ONE] && !evt_fall[1] && !do_wr) |=> $stable(st.tl1))
        else $error("counter one stepped without a pin fall");

    a_halt_one: assert property ( // [RULE11]
        (m1 == MODE_SPLIT && !do_wr) |=> ($stable(st.tl1) && $stable(st.th1)))
        else $error("timer one moved while halted");

    a_split_high: assert property ( // [RULE13]
        (m0 == MODE_SPLIT && !st.ctl[CTL_RUN_BIT_ONE] && !do_wr) |=> $stable(st.th0))
        else $error("split high byte counted without run bit one");

    a_ext_ack_clear: assert property ( // [RULE5]
        (st.ctl[CTL_EXT_IRQ_TYPE_ZERO] && EXT_IRQ_FLAG_ZERO && IRQ_ACK_EXT_ZERO
         && !ext_fall[0] && !wr_ctl) |=> !EXT_IRQ_FLAG_ZERO)
        else $error("edge interrupt zero not cleared on service");

    a_ext1_edge_set: assert property ( // [RULE5]
        (st.ctl[CTL_EXT_IRQ_TYPE_ONE] && ext_fall[1]) |=> EXT_IRQ_FLAG_ONE)
        else $error("edge interrupt one missed");

    a_ext_level_zero: assert property ( // [RULE6]
        !st.ctl[CTL_EXT_IRQ_TYPE_ZERO] |=> (EXT_IRQ_FLAG_ZERO == !$past(pin_high[0])))
        else $error("level interrupt zero not following pin");

    a_apb_wait_state: assert property (
        (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
        else $error("APB answer not after one wait state");

endmodule // dtc_top

`default_nettype wire

// ==== pkg/dtc_pkg.sv ====
// Constants for the dual timer/counter block.
// Assumes a 32-bit APB master and a processor core sharing CORE_CLK.
`default_nettype none

package dtc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CONTROL        = 8'h88;
    localparam logic [7:0] IDX_TIMER_MODE_CONTROL   = 8'h89;
    localparam logic [7:0] IDX_TIMER_ZERO_LOW_BYTE  = 8'h8A;
    localparam logic [7:0] IDX_TIMER_ONE_LOW_BYTE   = 8'h8B;
    localparam logic [7:0] IDX_TIMER_ZERO_HIGH_BYTE = 8'h8C;
    localparam logic [7:0] IDX_TIMER_ONE_HIGH_BYTE  = 8'h8D;

    // Reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_MODE    = 8'h00;
    localparam logic [7:0] RST_COUNT_BYTE    = 8'h00;

    // Control register bit positions
    localparam int CTL_OVERFLOW_FLAG_ONE  = 7;
    localparam int CTL_RUN_BIT_ONE        = 6;
    localparam int CTL_OVERFLOW_FLAG_ZERO = 5;
    localparam int CTL_RUN_BIT_ZERO       = 4;
    localparam int CTL_EXT_IRQ_FLAG_ONE   = 3;
    localparam int CTL_EXT_IRQ_TYPE_ONE   = 2;
    localparam int CTL_EXT_IRQ_FLAG_ZERO  = 1;
    localparam int CTL_EXT_IRQ_TYPE_ZERO  = 0;

    // Mode register field positions
    localparam int MOD_PIN_GATING_ONE     = 7;
    localparam int MOD_SOURCE_SELECT_ONE  = 6;
    localparam int MOD_MODE_HIGH_BIT_ONE  = 5;
    localparam int MOD_MODE_LOW_BIT_ONE   = 4;
    localparam int MOD_PIN_GATING_ZERO    = 3;
    localparam int MOD_SOURCE_SELECT_ZERO = 2;
    localparam int MOD_MODE_HIGH_BIT_ZERO = 1;
    localparam int MOD_MODE_LOW_BIT_ZERO  = 0;

    // Operating modes
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // Peripheral cycle: system clocks per count tick
    localparam int         PERIPH_CLOCKS = 6;
    localparam logic [2:0] DIV_LAST      = 3'(PERIPH_CLOCKS - 1);
    localparam logic [2:0] DIV_RESET     = 3'h0;
    localparam logic [3:0] SYNC_RESET    = 4'hF;

    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  mode;
        logic [7:0]  tl0;
        logic [7:0]  th0;
        logic [7:0]  tl1;
        logic [7:0]  th1;
        logic [2:0]  div;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  sync3;
        logic [1:0]  evt_prev;
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } dtc_state_t;

endpackage

`default_nettype wire

// ==== testbench/dtc_core_model.sv ====
// Core model: vectors to a routine once an enabled flag has stood for delay plus one cycles.
// Assumes flags and acks share the bench clock; ack is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module dtc_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] flags,
    input  wire logic [3:0] ack_en,
    input  wire logic [3:0] delay,
    output var  logic [3:0] ack
);
    logic [3:0] wait_r [4];

    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            ack[i] <= 1'b0;
            if (!rst_n || !flags[i] || !ack_en[i] || ack[i]) begin
                wait_r[i] <= 4'h0;
            end else if (wait_r[i] == delay) begin
                ack[i] <= 1'b1;
            end else begin
                wait_r[i] <= wait_r[i] + 4'h1;
            end
        end
    end
endmodule // dtc_core_model
`default_nettype wire

// ==== testbench/dual_timer_counter_bench.sv ====
// Bench for the dual timer/counter: APB master tasks and directed tests.
// Assumes the core model answers flags; run bits cleared before mode writes.
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_bench
    import dtc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    logic        ext0_n, ext1_n, evt0, evt1;
    logic [3:0]  ack_en, delay;
    wire  [3:0]  flags, ack;
    logic [7:0]  rv;
    logic        sv;
    int          fail_count = 0;
    int          total_checks = 0;
    logic [7:0]  regs [6] = '{IDX_TIMER_CONTROL, IDX_TIMER_MODE_CONTROL, IDX_TIMER_ZERO_LOW_BYTE,
                             IDX_TIMER_ONE_LOW_BYTE, IDX_TIMER_ZERO_HIGH_BYTE,
                             IDX_TIMER_ONE_HIGH_BYTE};

    always #5 clk = ~clk;

    dtc_top i_dtc_top (
        .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_IRQ_PIN_ZERO_N(ext0_n), .EXT_IRQ_PIN_ONE_N(ext1_n),
        .EVENT_PIN_ZERO(evt0), .EVENT_PIN_ONE(evt1),
        .IRQ_ACK_OVF_ZERO(ack[0]), .IRQ_ACK_OVF_ONE(ack[1]),
        .IRQ_ACK_EXT_ZERO(ack[2]), .IRQ_ACK_EXT_ONE(ack[3]),
        .OVERFLOW_FLAG_ZERO(flags[0]), .OVERFLOW_FLAG_ONE(flags[1]),
        .EXT_IRQ_FLAG_ZERO(flags[2]), .EXT_IRQ_FLAG_ONE(flags[3])
    );

    dtc_core_model i_dtc_core_model (
        .clk(clk), .rst_n(rst_n), .flags(flags), .ack_en(ack_en), .delay(delay), .ack(ack)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= 12'({idx, 2'b00});
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) fail_count++;
        rv = prdata[7:0];
        sv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check($sformatf("reg %h", idx), rv, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Run with the given control value for n cycles, then write zero to the control register
    task automatic run(input logic [7:0] c, input int n);
        wr(IDX_TIMER_CONTROL, c);
        cyc(n);
        wr(IDX_TIMER_CONTROL, 8'h00);
    endtask

    task automatic wflag(input int b, input logic v);
        int n;
        n = 0;
        while (flags[b] !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
        check("flag", 8'(flags[b]), 8'(v));
    endtask

    initial begin
        repeat (10000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        rst_n <= 1'b0; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
        paddr <= 12'h000; pwdata <= 32'h0; ext0_n <= 1'b1; ext1_n <= 1'b1;
        evt0 <= 1'b1; evt1 <= 1'b1; ack_en <= 4'h0; delay <= 4'h2;
        cyc(12);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rchk(regs[i], 8'h00);
        for (int i = 1; i < 6; i++) wr(regs[i], 8'h31 + 8'(i));
        for (int i = 1; i < 6; i++) rchk(regs[i], 8'h31 + 8'(i));
        apb(1'b0, 8'h8E, 8'h00);
        check("unmapped", {sv, rv[6:0]}, 8'h80);
        // Mode writes below follow a stop, except 8'h30, written while timer one runs in split mode of timer zero
        wr(IDX_TIMER_MODE_CONTROL, 8'h01);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        wr(IDX_TIMER_ZERO_HIGH_BYTE, 8'h00);
        run(8'h00, 30);
        rchk(IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        run(8'h10, 60);
        apb(1'b0, IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        check("rate", 8'(rv >= 8'h09 && rv <= 8'h0C), 8'h01);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'hFF);
        wr(IDX_TIMER_ZERO_HIGH_BYTE, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'h10);
        wflag(0, 1'b1);
        wr(IDX_TIMER_CONTROL, 8'h00);
        check("sw clear", 8'(flags[0]), 8'h00);
        rchk(IDX_TIMER_ZERO_HIGH_BYTE, 8'h00);
        wr(IDX_TIMER_MODE_CONTROL, 8'h20);
        wr(IDX_TIMER_ONE_HIGH_BYTE, 8'hF0);
        wr(IDX_TIMER_ONE_LOW_BYTE, 8'hFE);
        run(8'h00, 20);
        rchk(IDX_TIMER_ONE_LOW_BYTE, 8'hFE);
        ack_en <= 4'b0010;
        wr(IDX_TIMER_CONTROL, 8'h40);
        wflag(1, 1'b1);
        wflag(1, 1'b0);
        wr(IDX_TIMER_CONTROL, 8'h00);
        ack_en <= 4'b0000;
        rchk(IDX_TIMER_ONE_HIGH_BYTE, 8'hF0);
        apb(1'b0, IDX_TIMER_ONE_LOW_BYTE, 8'h00);
        check("reload", 8'(rv >= 8'hF0), 8'h01);
        wr(IDX_TIMER_MODE_CONTROL, 8'h02);
        wr(IDX_TIMER_ZERO_HIGH_BYTE, 8'hF8);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'hFE);
        wr(IDX_TIMER_CONTROL, 8'h10);
        wflag(0, 1'b1);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rchk(IDX_TIMER_ZERO_HIGH_BYTE, 8'hF8);
        apb(1'b0, IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        check("reload zero", 8'(rv >= 8'hF8), 8'h01);
        wr(IDX_TIMER_MODE_CONTROL, 8'h00);
        wr(IDX_TIMER_ZERO_HIGH_BYTE, 8'h05);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'hFF);
        run(8'h10, 20);
        rchk(IDX_TIMER_ZERO_HIGH_BYTE, 8'h06);
        apb(1'b0, IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        check("prescaler", rv & 8'hE0, 8'hE0);
        wr(IDX_TIMER_MODE_CONTROL, 8'h03);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'h10);
        wr(IDX_TIMER_ZERO_HIGH_BYTE, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'h40);
        wflag(1, 1'b1);
        wr(IDX_TIMER_CONTROL, 8'h00);
        check("split flag zero", 8'(flags[0]), 8'h00);
        rchk(IDX_TIMER_ZERO_LOW_BYTE, 8'h10);
        wr(IDX_TIMER_MODE_CONTROL, 8'h30);
        wr(IDX_TIMER_ONE_LOW_BYTE, 8'h20);
        run(8'h40, 30);
        rchk(IDX_TIMER_ONE_LOW_BYTE, 8'h20);
        wr(IDX_TIMER_MODE_CONTROL, 8'h99);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        wr(IDX_TIMER_ONE_LOW_BYTE, 8'h00);
        ext0_n <= 1'b0;
        ext1_n <= 1'b0;
        wflag(2, 1'b1);
        wflag(3, 1'b1);
        run(8'h50, 30);
        rchk(IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        rchk(IDX_TIMER_ONE_LOW_BYTE, 8'h00);
        ext0_n <= 1'b1;
        ext1_n <= 1'b1;
        wflag(2, 1'b0);
        run(8'h50, 30);
        apb(1'b0, IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        check("gate open zero", 8'(rv != 8'h00), 8'h01);
        apb(1'b0, IDX_TIMER_ONE_LOW_BYTE, 8'h00);
        check("gate open one", 8'(rv != 8'h00), 8'h01);
        wr(IDX_TIMER_CONTROL, 8'h05);
        ack_en <= 4'b0100;
        ext0_n <= 1'b0;
        ext1_n <= 1'b0;
        wflag(2, 1'b1);
        wflag(2, 1'b0);
        ext0_n <= 1'b1;
        ext1_n <= 1'b1;
        cyc(10);
        check("edge held", 8'(flags[3]), 8'h01);
        ack_en <= 4'b1000;
        wflag(3, 1'b0);
        ack_en <= 4'b0000;
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_TIMER_MODE_CONTROL, 8'h55);
        wr(IDX_TIMER_ZERO_LOW_BYTE, 8'h00);
        wr(IDX_TIMER_ONE_LOW_BYTE, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h50);
        repeat (3) begin
            evt0 <= 1'b0;
            evt1 <= 1'b0;
            cyc(20);
            evt0 <= 1'b1;
            evt1 <= 1'b1;
            cyc(20);
        end
        wr(IDX_TIMER_CONTROL, 8'h00);
        rchk(IDX_TIMER_ZERO_LOW_BYTE, 8'h03);
        rchk(IDX_TIMER_ONE_LOW_BYTE, 8'h03);
        end_sim();
    end
endmodule // dual_timer_counter_bench
`default_nettype wire
